// File: include/io_port_pkg.sv
// Package with the register map, pin masks and bus carrier of the I/O ports.
package io_port_pkg;

   localparam int NUM_PORTS = 7;
   localparam int PORT_A    = 0;
   localparam int PORT_B    = 1;
   localparam int PORT_C    = 2;
   localparam int PORT_D    = 3;
   localparam int PORT_E    = 4;
   localparam int PORT_F    = 5;
   localparam int PORT_G    = 6;

   // Register groups; the port index is added to the group offset.
   localparam logic [7:0] OFS_DATA_IN    = 8'h00;
   localparam logic [7:0] OFS_DATA_OUT   = 8'h08;
   localparam logic [7:0] OFS_DIRECTION  = 8'h10;
   localparam logic [7:0] OFS_DRIVE_SEL  = 8'h18;
   localparam logic [7:0] OFS_ADDR_SEL   = 8'h20;
   localparam logic [7:0] OFS_ENABLE_OUT = 8'h28;
   localparam logic [7:0] OFS_CELL_OUT   = 8'h30;
   localparam logic [7:0] OFS_CELL_MASK  = 8'h38;
   localparam logic [7:0] OFS_MEM_MODE   = 8'h40;
   localparam logic [4:0] GROUP_MASK     = 5'h1f;

   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam int         PERIPH_MODE_BIT = 7;

   // Pins that exist on each port; port D has four.
   localparam logic [NUM_PORTS-1:0][7:0] PIN_MASK =
      {8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
   // Ports with an output-enable product term: A, B, C and F.
   localparam logic [NUM_PORTS-1:0] HAS_TERM = 7'b0100111;
   // Ports with an address-output select register: E, F and G.
   localparam logic [NUM_PORTS-1:0] HAS_ADDR_SEL = 7'b1110000;
   // Ports whose drive-select bits set slew rate: C and F.
   localparam logic [NUM_PORTS-1:0] DRIVE_IS_SLEW = 7'b0100100;
   // Ports with output logic cells: A and B.
   localparam int NUM_CELL_PORTS = 2;

   typedef struct packed {
      logic       sel;
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } io_bus_req_t;

   typedef struct packed {
      logic [7:0] en;
      logic [7:0] drive;
      logic [7:0] val;
   } pin_override_t;

endpackage

// File: src/port_pin_ctrl.sv
// Per-port pin driver selection: direction, address output, drive mode.
`timescale 1ns/1ps
module port_pin_ctrl #(
   parameter logic [7:0] PIN_MASK  = 8'hff,
   parameter bit         HAS_TERM  = 1'b0,
   parameter bit         HAS_SEL   = 1'b0,
   parameter bit         IS_SLEW   = 1'b0
) (
   // Configuration
   input  wire logic [7:0]                direction_in,
   input  wire logic [7:0]                drive_sel_in,
   input  wire logic [7:0]                addr_sel_in,
   // Sources
   input  wire logic [7:0]                oe_term_in,
   input  wire logic [7:0]                data_in,
   input  wire logic [7:0]                addr_in,
   input  wire io_port_pkg::pin_override_t ovr_in,
   // Pin controls
   output logic      [7:0]                pin_val_out,
   output logic      [7:0]                pin_oe_n_out,
   output logic      [7:0]                slew_fast_out,
   output logic      [7:0]                enabled_out
);

   logic [7:0] term;
   logic [7:0] en_norm;
   logic [7:0] val_norm;
   logic [7:0] en;
   logic [7:0] val;
   logic [7:0] open_drain;

   always_comb begin
      term     = HAS_TERM ? oe_term_in : 8'h00;
      en_norm  = direction_in | term;
      val_norm = HAS_SEL ? ((addr_sel_in & addr_in) |
                            (~addr_sel_in & data_in)) : data_in;
      en       = ((ovr_in.en & ovr_in.drive) |
                  (~ovr_in.en & en_norm)) & PIN_MASK;
      val      = (ovr_in.en & ovr_in.val) | (~ovr_in.en & val_norm);
      // Overrides always drive push-pull so bus patterns are full swing.
      open_drain = IS_SLEW ? 8'h00 : (drive_sel_in & ~ovr_in.en);
      enabled_out   = en;
      pin_oe_n_out  = ~(en & (~open_drain | ~val));
      pin_val_out   = val & ~open_drain;
      slew_fast_out = IS_SLEW ? (drive_sel_in & PIN_MASK) : 8'h00;
   end

endmodule

// File: src/io_port_config_and_data.sv
// Configuration and data registers of seven I/O ports with pin drivers.
`timescale 1ns/1ps
// Functional notes
// - Memory mode bit 7 set turns port F into a peripheral data buffer.
// - Peripheral buffer drives only while a peripheral select term is active.
// - Reset pattern drives ports F and G during reset without bus cycle.
// - After reset, ports F and G resume normal function.
// - Each register bit except memory mode bit 7 controls only the pin of the same index.
// - Address select, direction and drive select reset to zero.
// - Ports E, F, G: address select 0 is I/O, 1 latched address.
// - Direction 1 makes an output, 0 an input; default is input.
// - Ports A, B, C, F: output when direction or enable term is set.
// - Port D direction uses only its four low bits.
// - Drive select 1 gives open drain where supported; default push-pull.
// - Drive select 1 gives fast slew where supported; default slow.
// - Open drain on A, B, E, G, D3-0; slew on C and F.
// - Data-in reads return the live pin levels.
// - Data-out stores writes, drives enabled pins, reads back.
// - Output logic cells readable; writes load them unless masked.
// - Mask bit 1 blocks loading its logic cell; masks reset to zero.
// - Configuration registers are read and written by ordinary bus cycles.
// - Port E pins may be given over to in-system programming.
// - Address output drives when select and direction are set, or on port F select and enable term.
// - Enable status of A, B, C, F reads 1 while output enabled, 0 while input.
module io_port_config_and_data #(
   parameter bit                         RESET_PATTERN_EN = 1'b0,
   parameter logic [15:0]                RESET_PATTERN    = 16'h0000,
   parameter logic [7:0]                 PROG_PIN_MASK    = 8'hff,
   parameter bit                         G_ADDR_HIGH      = 1'b1
) (
   // Clock and reset
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_n_in,
   // Processor bus
   input  wire io_port_pkg::io_bus_req_t bus_req_in,
   input  wire logic                     bus_cycle_in,
   input  wire logic                     mcu_reset_in,
   input  wire logic [15:0]              latched_addr_in,
   output logic      [7:0]               bus_rdata_out,
   // Programmable logic
   input  wire logic [6:0][7:0]          oe_term_in,
   input  wire logic                     periph_select_a_in,
   input  wire logic                     periph_select_b_in,
   input  wire logic                     prog_enable_in,
   output logic      [1:0][7:0]          cell_out_out,
   // Pins
   input  wire logic [6:0][7:0]          pin_in,
   output logic      [6:0][7:0]          pin_out,
   output logic      [6:0][7:0]          pin_oe_n_out,
   output logic      [6:0][7:0]          slew_fast_out
);

   localparam int NP = io_port_pkg::NUM_PORTS;

   logic [NP-1:0][7:0] direction_r;
   logic [NP-1:0][7:0] drive_sel_r;
   logic [NP-1:0][7:0] addr_sel_r;
   logic [NP-1:0][7:0] data_out_r;
   logic [1:0][7:0]    cell_r;
   logic [1:0][7:0]    cell_mask_r;
   logic [7:0]         mem_mode_r;
   logic [NP-1:0][7:0] enabled_r;

   logic [NP-1:0][7:0] pin_val_nxt;
   logic [NP-1:0][7:0] pin_oe_n_nxt;
   logic [NP-1:0][7:0] slew_nxt;
   logic [NP-1:0][7:0] enabled_nxt;
   logic [NP-1:0][7:0] src_data;
   logic [NP-1:0][7:0] src_addr;
   io_port_pkg::pin_override_t [NP-1:0] ovr;

   logic       periph_mode;
   logic       periph_sel;
   logic       reset_drive;
   logic [4:0] group;
   logic [2:0] port_idx;
   logic       port_ok;
   logic [7:0] rdata_nxt;

   assign periph_mode = mem_mode_r[io_port_pkg::PERIPH_MODE_BIT];
   assign periph_sel  = periph_mode &
                        (periph_select_a_in | periph_select_b_in);
   // Only while reset is held and the bus is idle; released on exit.
   assign reset_drive = RESET_PATTERN_EN & mcu_reset_in &
                        ~bus_cycle_in;
   assign group       = bus_req_in.addr[7:3];
   assign port_idx    = bus_req_in.addr[2:0];
   assign port_ok     = port_idx < 3'(NP);

   // Register writes through the processor bus.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         for (int p = 0; p < NP; p++) begin
            direction_r[p] <= io_port_pkg::REG_RESET;
            drive_sel_r[p] <= io_port_pkg::REG_RESET;
            addr_sel_r[p]  <= io_port_pkg::REG_RESET;
            data_out_r[p]  <= io_port_pkg::REG_RESET;
         end
         mem_mode_r <= io_port_pkg::REG_RESET;
      end else if (bus_req_in.sel && bus_req_in.wr && port_ok) begin
         for (int p = 0; p < NP; p++) begin
            if (port_idx == 3'(p)) begin
               case (group)
                  io_port_pkg::OFS_DATA_OUT[7:3]: begin
                     data_out_r[p] <= bus_req_in.wdata &
                                      io_port_pkg::PIN_MASK[p];
                  end
                  io_port_pkg::OFS_DIRECTION[7:3]: begin
                     direction_r[p] <= bus_req_in.wdata &
                                       io_port_pkg::PIN_MASK[p];
                  end
                  io_port_pkg::OFS_DRIVE_SEL[7:3]: begin
                     drive_sel_r[p] <= bus_req_in.wdata &
                                       io_port_pkg::PIN_MASK[p];
                  end
                  io_port_pkg::OFS_ADDR_SEL[7:3]: begin
                     if (io_port_pkg::HAS_ADDR_SEL[p]) begin
                        addr_sel_r[p] <= bus_req_in.wdata;
                     end
                  end
                  io_port_pkg::OFS_MEM_MODE[7:3]: begin
                     if (p == 0) begin
                        mem_mode_r <= bus_req_in.wdata;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // Output logic cells with their load masks.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cell_r      <= '0;
         cell_mask_r <= '0;
      end else if (bus_req_in.sel && bus_req_in.wr &&
                   port_idx < 3'(io_port_pkg::NUM_CELL_PORTS)) begin
         if (group == io_port_pkg::OFS_CELL_OUT[7:3]) begin
            cell_r[port_idx[0]] <=
               (cell_r[port_idx[0]] & cell_mask_r[port_idx[0]]) |
               (bus_req_in.wdata & ~cell_mask_r[port_idx[0]]);
         end
         if (group == io_port_pkg::OFS_CELL_MASK[7:3]) begin
            cell_mask_r[port_idx[0]] <= bus_req_in.wdata;
         end
      end
   end

   // Per-port data sources and overrides.
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         src_data[p] = data_out_r[p];
         ovr[p]      = '0;
      end
      for (int c = 0; c < io_port_pkg::NUM_CELL_PORTS; c++) begin
         src_data[c] = (oe_term_in[c] & cell_r[c]) |
                       (~oe_term_in[c] & data_out_r[c]);
      end
      src_addr = '0;
      src_addr[io_port_pkg::PORT_E] = latched_addr_in[7:0];
      src_addr[io_port_pkg::PORT_F] = latched_addr_in[7:0];
      src_addr[io_port_pkg::PORT_G] = G_ADDR_HIGH ?
                                      latched_addr_in[15:8] :
                                      latched_addr_in[7:0];
      if (prog_enable_in) begin
         ovr[io_port_pkg::PORT_E].en = PROG_PIN_MASK;
      end
      if (periph_mode) begin
         ovr[io_port_pkg::PORT_F].en    = 8'hff;
         ovr[io_port_pkg::PORT_F].drive = {8{periph_sel &
                                           bus_req_in.wr}};
         ovr[io_port_pkg::PORT_F].val   = bus_req_in.wdata;
      end
      if (reset_drive) begin
         ovr[io_port_pkg::PORT_F] = '{8'hff, 8'hff,
                                      RESET_PATTERN[7:0]};
         ovr[io_port_pkg::PORT_G] = '{8'hff, 8'hff,
                                      RESET_PATTERN[15:8]};
      end
   end

   for (genvar g = 0; g < NP; g++) begin : gen_port
      port_pin_ctrl #(
         .PIN_MASK (io_port_pkg::PIN_MASK[g]),
         .HAS_TERM (io_port_pkg::HAS_TERM[g]),
         .HAS_SEL  (io_port_pkg::HAS_ADDR_SEL[g]),
         .IS_SLEW  (io_port_pkg::DRIVE_IS_SLEW[g])
      ) u_pin (
         .direction_in  (direction_r[g]),
         .drive_sel_in  (drive_sel_r[g]),
         .addr_sel_in   (addr_sel_r[g]),
         .oe_term_in    (oe_term_in[g]),
         .data_in       (src_data[g]),
         .addr_in       (src_addr[g]),
         .ovr_in        (ovr[g]),
         .pin_val_out   (pin_val_nxt[g]),
         .pin_oe_n_out  (pin_oe_n_nxt[g]),
         .slew_fast_out (slew_nxt[g]),
         .enabled_out   (enabled_nxt[g])
      );
   end

   // Pin drivers are registered so every output comes from a flop.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pin_out       <= '0;
         pin_oe_n_out  <= '1;
         slew_fast_out <= '0;
         enabled_r     <= '0;
      end else begin
         pin_out       <= pin_val_nxt;
         pin_oe_n_out  <= pin_oe_n_nxt;
         slew_fast_out <= slew_nxt;
         enabled_r     <= enabled_nxt;
      end
   end

   // Read data selection.
   always_comb begin
      rdata_nxt = 8'h00;
      if (periph_sel && bus_req_in.rd) begin
         rdata_nxt = pin_in[io_port_pkg::PORT_F];
      end else if (bus_req_in.sel && bus_req_in.rd && port_ok) begin
         case (group)
            io_port_pkg::OFS_DATA_IN[7:3]: begin
               rdata_nxt = pin_in[port_idx] &
                           io_port_pkg::PIN_MASK[port_idx];
            end
            io_port_pkg::OFS_DATA_OUT[7:3]: begin
               rdata_nxt = data_out_r[port_idx];
            end
            io_port_pkg::OFS_DIRECTION[7:3]: begin
               rdata_nxt = direction_r[port_idx];
            end
            io_port_pkg::OFS_DRIVE_SEL[7:3]: begin
               rdata_nxt = drive_sel_r[port_idx];
            end
            io_port_pkg::OFS_ADDR_SEL[7:3]: begin
               rdata_nxt = addr_sel_r[port_idx];
            end
            io_port_pkg::OFS_ENABLE_OUT[7:3]: begin
               if (io_port_pkg::HAS_TERM[port_idx]) begin
                  rdata_nxt = enabled_r[port_idx];
               end
            end
            io_port_pkg::OFS_CELL_OUT[7:3]: begin
               if (port_idx < 3'(io_port_pkg::NUM_CELL_PORTS)) begin
                  rdata_nxt = cell_r[port_idx[0]];
               end
            end
            io_port_pkg::OFS_CELL_MASK[7:3]: begin
               if (port_idx < 3'(io_port_pkg::NUM_CELL_PORTS)) begin
                  rdata_nxt = cell_mask_r[port_idx[0]];
               end
            end
            io_port_pkg::OFS_MEM_MODE[7:3]: begin
               if (port_idx == 3'h0) begin
                  rdata_nxt = mem_mode_r;
               end
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         bus_rdata_out <= 8'h00;
         cell_out_out  <= '0;
      end else begin
         bus_rdata_out <= rdata_nxt;
         cell_out_out  <= cell_r;
      end
   end

endmodule

// File: dv/io_port_config_and_data_assertions.sv
// Concurrent checks on the I/O port block's pins and bus answers.
`timescale 1ns/1ps
module io_port_checker #(
   parameter bit          RESET_PATTERN_EN = 1'b0,
   parameter logic [15:0] RESET_PATTERN    = 16'h0000,
   parameter logic [7:0]  PROG_PIN_MASK    = 8'hff
) (
   // Clock and reset
   input wire logic                     sys_clk_in,
   input wire logic                     rst_n_in,
   // Processor bus
   input wire io_port_pkg::io_bus_req_t bus_req_in,
   input wire logic                     bus_cycle_in,
   input wire logic                     mcu_reset_in,
   input wire logic [7:0]               bus_rdata_out,
   // Programmable logic
   input wire logic [6:0][7:0]          oe_term_in,
   input wire logic                     periph_select_a_in,
   input wire logic                     periph_select_b_in,
   input wire logic                     prog_enable_in,
   input wire logic [1:0][7:0]          cell_out_out,
   // Pins
   input wire logic [6:0][7:0]          pin_in,
   input wire logic [6:0][7:0]          pin_out,
   input wire logic [6:0][7:0]          pin_oe_n_out,
   input wire logic [6:0][7:0]          slew_fast_out
);
   logic mode_r;
   logic psel;
   assign psel = periph_select_a_in | periph_select_b_in;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Shadow of the peripheral mode bit, to know when port F is a buffer.
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         mode_r <= 1'b0;
      end else if (bus_req_in.sel && bus_req_in.wr &&
                   bus_req_in.addr == io_port_pkg::OFS_MEM_MODE) begin
         mode_r <= bus_req_in.wdata[io_port_pkg::PERIPH_MODE_BIT];
      end
   end
   sequence periph_wr_s;
      mode_r && psel && bus_req_in.wr && !mcu_reset_in;
   endsequence
   sequence pattern_on_s;
      RESET_PATTERN_EN && mcu_reset_in && !bus_cycle_in;
   endsequence
   reset_outputs_clear_a: assert property (
      $rose(rst_n_in) |-> bus_rdata_out == 8'h00 && cell_out_out == '0)
      else $error("outputs not clear after reset");
   slew_ports_only_a: assert property (
      (slew_fast_out[0] | slew_fast_out[1] | slew_fast_out[3] |
       slew_fast_out[4] | slew_fast_out[6]) == 8'h00)
      else $error("fast slew on a port without slew control");
   port_d_upper_a: assert property (pin_oe_n_out[3][7:4] == 4'hf)
      else $error("missing port D pin driven");
   data_in_read_a: assert property (
      bus_req_in.sel && bus_req_in.rd && bus_req_in.addr == 8'h02 && !psel
      |=> bus_rdata_out == $past(pin_in[2]))
      else $error("data in read not the live pins");
   idle_rdata_zero_a: assert property (
      !(bus_req_in.sel && bus_req_in.rd) && !psel |=> bus_rdata_out == 8'h00)
      else $error("read data without a read");
   periph_drive_a: assert property (periph_wr_s |=>
      pin_oe_n_out[5] == 8'h00 && pin_out[5] == $past(bus_req_in.wdata))
      else $error("peripheral buffer not driving write data");
   periph_float_a: assert property (
      mode_r && !psel && !mcu_reset_in |=> pin_oe_n_out[5] == 8'hff)
      else $error("peripheral buffer driving without select");
   reset_pattern_a: assert property (pattern_on_s |=>
      {pin_oe_n_out[6], pin_oe_n_out[5]} == 16'h0000 &&
      {pin_out[6], pin_out[5]} == RESET_PATTERN)
      else $error("reset pattern not driven");
   term_enable_a: assert property (oe_term_in[2] != 8'h00 |=>
      (pin_oe_n_out[2] & $past(oe_term_in[2])) == 8'h00)
      else $error("enable term did not turn pin to output");
   prog_release_a: assert property (prog_enable_in |=>
      (pin_oe_n_out[4] | ~PROG_PIN_MASK) == 8'hff)
      else $error("port E driven while programming");
endmodule
bind io_port_config_and_data io_port_checker #(
   .RESET_PATTERN_EN(RESET_PATTERN_EN),
   .RESET_PATTERN   (RESET_PATTERN),
   .PROG_PIN_MASK   (PROG_PIN_MASK)
) checker_i (
   .sys_clk_in, .rst_n_in, .bus_req_in, .bus_cycle_in, .mcu_reset_in,
   .bus_rdata_out, .oe_term_in, .periph_select_a_in, .periph_select_b_in,
   .prog_enable_in, .cell_out_out, .pin_in, .pin_out, .pin_oe_n_out,
   .slew_fast_out
);

// File: dv/io_pin_partner.sv
// Board model behind the port pins: pull-ups, outside drivers, boot word.
`timescale 1ns/1ps
module io_pin_partner (
   // Clock and processor reset
   input  wire logic            clk_in,
   input  wire logic            hold_in,
   // Block drivers and board drivers
   input  wire logic [6:0][7:0] drv_val_in,
   input  wire logic [6:0][7:0] drv_oe_n_in,
   input  wire logic [6:0][7:0] ext_en_in,
   input  wire logic [6:0][7:0] ext_val_in,
   // Pin levels and sampled boot word
   output logic      [6:0][7:0] pin_lvl_out,
   output logic      [15:0]     boot_cfg_out
);
   // A pin that nobody drives floats up through its pull-up resistor.
   assign pin_lvl_out = (~drv_oe_n_in & drv_val_in) |
                        (drv_oe_n_in & ext_en_in & ext_val_in) |
                        (drv_oe_n_in & ~ext_en_in);
   // The processor keeps the last data word seen before its reset lifts.
   always_ff @(posedge clk_in) begin
      if (hold_in) begin
         boot_cfg_out <= {pin_lvl_out[6], pin_lvl_out[5]};
      end
   end
endmodule

// File: dv/test_io_port_config_and_data.sv
// Self-checking bench for the I/O port block and its pin partner.
`timescale 1ns/1ps
module test_io_port_config_and_data;
   localparam logic [15:0] PATTERN = 16'hc35a;
   localparam int          LIMIT   = 4000;
   logic                     sys_clk_in = 1'b0;
   logic                     rst_n_in = 1'b0;
   io_port_pkg::io_bus_req_t req = '0;
   logic                     bus_cycle = 1'b0;
   logic                     mcu_reset = 1'b0;
   logic [15:0]              laddr = 16'h1234;
   logic [6:0][7:0]          term = '0;
   logic                     psel_a = 1'b0;
   logic                     psel_b = 1'b0;
   logic                     prog = 1'b0;
   logic [6:0][7:0]          ext_en = '0;
   logic [6:0][7:0]          ext_val = '0;
   logic [7:0]               rdata;
   logic [1:0][7:0]          cells;
   logic [6:0][7:0]          pins;
   logic [6:0][7:0]          pval;
   logic [6:0][7:0]          oe_n;
   logic [6:0][7:0]          slew;
   logic [15:0]              boot_cfg;
   int                       err_total = 0;
   int                       n_tests = 0;
   int                       cyc = 0;

   always #2 sys_clk_in = ~sys_clk_in;

   io_port_config_and_data #(
      .RESET_PATTERN_EN(1'b1),
      .RESET_PATTERN   (PATTERN)
   ) dut (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus_req_in(req),
      .bus_cycle_in(bus_cycle), .mcu_reset_in(mcu_reset),
      .latched_addr_in(laddr), .bus_rdata_out(rdata),
      .oe_term_in(term), .periph_select_a_in(psel_a),
      .periph_select_b_in(psel_b), .prog_enable_in(prog),
      .cell_out_out(cells), .pin_in(pins), .pin_out(pval),
      .pin_oe_n_out(oe_n), .slew_fast_out(slew)
   );

   io_pin_partner board (
      .clk_in(sys_clk_in), .hold_in(mcu_reset), .drv_val_in(pval),
      .drv_oe_n_in(oe_n), .ext_en_in(ext_en), .ext_val_in(ext_val),
      .pin_lvl_out(pins), .boot_cfg_out(boot_cfg)
   );

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One bus request, held for exactly one sampling edge.
   task automatic put(input logic s, r, w, input logic [7:0] a, d);
      @(posedge sys_clk_in);
      req <= '{sel: s, rd: r, wr: w, addr: a, wdata: d};
      @(posedge sys_clk_in);
      req <= '0;
   endtask

   task automatic wr(input logic [7:0] a, d);
      put(1'b1, 1'b0, 1'b1, a, d);
   endtask

   task automatic rd(input string n, input logic [7:0] a, exp);
      put(1'b1, 1'b1, 1'b0, a, 8'h00);
      #1 chk(n, rdata, exp);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         wrap_up();
      end
   end

   initial begin
      repeat (6) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      // Look at the outputs only once they have settled after the edge.
      #1;
      for (int p = 0; p < 7; p++) begin
         chk("oe_n", oe_n[p], 8'hff);
         rd("dir", io_port_pkg::OFS_DIRECTION + 8'(p), 8'h00);
         rd("drv", io_port_pkg::OFS_DRIVE_SEL + 8'(p), 8'h00);
         rd("asel", io_port_pkg::OFS_ADDR_SEL + 8'(p), 8'h00);
      end
      rd("mask_a", io_port_pkg::OFS_CELL_MASK, 8'h00);
      $display("test reset done");
      wr(8'h09, 8'h5a);
      wr(8'h11, 8'h0f);
      wait_n(1);
      chk("b_oe", oe_n[1], 8'hf0);
      chk("b_val", pval[1][3:0], 4'ha);
      rd("b_in", 8'h01, 8'hfa);
      rd("b_out", 8'h09, 8'h5a);
      wr(8'h19, 8'hff);
      wait_n(1);
      chk("b_od", oe_n[1], 8'hfa);
      wr(8'h1a, 8'hff);
      wait_n(1);
      chk("c_slew", {slew[2], slew[1]}, 16'hff00);
      wr(8'h1b, 8'hff);
      rd("d_drv", 8'h1b, 8'h0f);
      wr(8'h13, 8'hff);
      rd("d_dir", 8'h13, 8'h0f);
      $display("test direction done");
      wr(8'h0a, 8'hff);
      @(posedge sys_clk_in);
      term[2] <= 8'h81;
      ext_en[2] <= 8'hff;
      ext_val[2] <= 8'h3c;
      wait_n(2);
      chk("c_term", oe_n[2], 8'h7e);
      chk("c_val", pval[2] & 8'h81, 8'h81);
      rd("c_en", 8'h2a, 8'h81);
      rd("c_in", 8'h02, 8'hbd);
      @(posedge sys_clk_in);
      term[2] <= 8'h00;
      ext_en[2] <= 8'h00;
      wr(8'h0c, 8'h00);
      wr(8'h14, 8'hff);
      wr(8'h24, 8'h0f);
      wait_n(1);
      chk("e_addr", {oe_n[4], pval[4]}, 16'h0004);
      rd("e_sel", 8'h24, 8'h0f);
      wr(8'h16, 8'hff);
      wr(8'h26, 8'hff);
      wait_n(1);
      chk("g_addr", {oe_n[6], pval[6]}, 16'h0012);
      wr(8'h16, 8'h00);
      wr(8'h20, 8'hff);
      rd("a_sel", 8'h20, 8'h00);
      $display("test enables done");
      wr(8'h30, 8'h3c);
      rd("cell", 8'h30, 8'h3c);
      chk("cell_pin", cells[0], 8'h3c);
      wr(8'h38, 8'h0f);
      wr(8'h30, 8'hc3);
      rd("cell_m", 8'h30, 8'hcc);
      rd("unmap", 8'h48, 8'h00);
      rd("cell_c", 8'h32, 8'h00);
      $display("test cells done");
      wr(8'h40, 8'h80);
      wait_n(1);
      chk("f_float", oe_n[5], 8'hff);
      @(posedge sys_clk_in);
      psel_a <= 1'b1;
      put(1'b0, 1'b0, 1'b1, 8'h00, 8'h66);
      #1 chk("f_drv", {oe_n[5], pval[5]}, 16'h0066);
      @(posedge sys_clk_in);
      psel_a <= 1'b0;
      psel_b <= 1'b1;
      ext_en[5] <= 8'hff;
      ext_val[5] <= 8'h99;
      put(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
      #1 chk("f_rd", rdata, 8'h99);
      @(posedge sys_clk_in);
      psel_b <= 1'b0;
      ext_en <= '0;
      wr(8'h40, 8'h00);
      $display("test peripheral done");
      @(posedge sys_clk_in);
      mcu_reset <= 1'b1;
      wait_n(2);
      chk("fg_pat", {pval[6], pval[5]}, PATTERN);
      @(posedge sys_clk_in);
      bus_cycle <= 1'b1;
      wait_n(2);
      chk("f_cyc", oe_n[5], 8'hff);
      @(posedge sys_clk_in);
      bus_cycle <= 1'b0;
      wait_n(2);
      @(posedge sys_clk_in);
      mcu_reset <= 1'b0;
      wait_n(2);
      chk("fg_free", {oe_n[6], oe_n[5]}, 16'hffff);
      chk("boot", boot_cfg, PATTERN);
      @(posedge sys_clk_in);
      prog <= 1'b1;
      wait_n(2);
      chk("e_prog", oe_n[4], 8'hff);
      $display("test reset pattern done");
      wrap_up();
   end
endmodule
